//--- rtl/fml_pkg.sv
// Constants, field positions and carrier types of the fault register bank.
// Assumes a single clock domain; every user imports the whole package.
//
// Contract
// - Thermal shutdown shows in bit 0 of 0x72, read-only, upper bits zero.
// - The thermal warning at 135C shows in read-only bit 2 of 0x73.
// - Mask bit 7 of 0x74 hides thermal shutdown from the report; resets 0.
// - Mask bits 6, 5, 3, 2 hide core UV, core OV, rail UV, rail OV.
// - Mask bit 4 of 0x74 hides clock faults from the report.
// - Mask bits 1 and 0 hide output offset and overcurrent faults.
// - Bit 5 of 0x75 (reset one) makes a clock fault latch.
// - Bit 4 of 0x75 (reset one) makes a thermal shutdown latch.
// - Bit 3 of 0x75 (reset one) makes the thermal warning latch.
// - Bit 2 of 0x75 hides the thermal warning; resets to zero.
// - Bit 7 of 0x76 holds clock detect status, else it follows live.
// - Bit 4 of 0x76 enables thermal auto recovery; resets to zero.
// - Writing one to write-only bit 7 of 0x78 clears latched faults.
// - Left and right overcurrent are read-only bits 1 and 0 of 0x70.
// - Left and right offset faults are read-only bits 3 and 2 of 0x70.

`default_nettype none

package fml_pkg;

    localparam logic [7:0] CHAN_ADDR  = 8'h70;
    localparam logic [7:0] GLOB_ADDR  = 8'h71;
    localparam logic [7:0] TSD_ADDR   = 8'h72;
    localparam logic [7:0] WARN_ADDR  = 8'h73;
    localparam logic [7:0] MASK_ADDR  = 8'h74;
    localparam logic [7:0] LATCH_ADDR = 8'h75;
    localparam logic [7:0] MISC_ADDR  = 8'h76;
    localparam logic [7:0] CLR_ADDR   = 8'h78;
    localparam logic [7:0] DET_ADDR   = 8'h79;

    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] LATCH_RST  = 8'hf8;
    localparam logic [7:0] MISC_RST   = 8'h00;
    localparam logic [6:0] CLR_RST    = 7'h00;

    localparam int TSD_BIT  = 0;
    localparam int WARN_BIT = 2;
    localparam int MSK_WARN = 2;
    localparam int LE_CLK   = 5;
    localparam int LE_TSD   = 4;
    localparam int LE_WARN  = 3;
    localparam int HOLD_BIT = 7;
    localparam int AUTO_BIT = 4;
    localparam int CLR_BIT  = 7;
    localparam int CLK_BIT  = 2;
    localparam int COND_W   = 12;

    typedef struct packed {
        logic thermShut;
        logic thermWarn;
        logic clockErr;
        logic clockDet;
        logic coreUv;
        logic coreOv;
        logic railUv;
        logic railOv;
        logic leftOc;
        logic rightOc;
        logic leftDc;
        logic rightDc;
    } fml_cond_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } fml_wr_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_RECV = 6'b000100,
        ST_ACK  = 6'b001000,
        ST_SEND = 6'b010000,
        ST_MACK = 6'b100000
    } fml_st_t;

endpackage

`default_nettype wire

//--- rtl/fml_i2c_target.sv
// Two-wire control port target: address match, register pointer, writes
// and auto-incrementing reads. Assumes scl and sda are raw pins.

`default_nettype none

module fml_i2c_target
    import fml_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2c
) (
    input  wire logic       mclk,   // System clock.
    input  wire logic       rstn,   // Asynchronous reset, active low.
    input  wire logic       scl,    // Raw serial clock pin.
    input  wire logic       sdaIn,  // Raw serial data pin level.
    output var  logic       sdaOe,  // High while pulling data low.
    output var  fml_wr_t    wr,     // Register write, one-cycle valid.
    output var  logic [7:0] rdAddr, // Register pointer.
    input  wire logic [7:0] rdData  // Read data at the pointer.
);

    logic [1:0] pinM_q, pinS_q, pinP_q;
    fml_st_t    st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic       rw_q, rw_d, ptrOk_q, ptrOk_d, oe_d;
    fml_wr_t    wr_d;
    logic       sclRise, sclFall, start, stop;

    // Edges are taken from the second and third stages.
    assign sclRise = pinS_q[1] & ~pinP_q[1];
    assign sclFall = ~pinS_q[1] & pinP_q[1];
    assign start   = pinS_q[1] & pinP_q[1] & pinP_q[0] & ~pinS_q[0];
    assign stop    = pinS_q[1] & pinP_q[1] & ~pinP_q[0] & pinS_q[0];
    assign rdAddr  = ptr_q;

    always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        sh_d       = sh_q;
        ptr_d      = ptr_q;
        rw_d       = rw_q;
        ptrOk_d    = ptrOk_q;
        oe_d       = sdaOe;
        wr_d       = wr;
        wr_d.valid = 1'b0;
        if (start) begin
            st_d    = ST_ADDR;
            cnt_d   = 4'h0;
            ptrOk_d = 1'b0;
            oe_d    = 1'b0;
        end else if (stop) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: ;
                ST_ADDR, ST_RECV: begin
                    if (sclRise) begin
                        sh_d  = {sh_q[6:0], pinS_q[0]};
                        cnt_d = cnt_q + 4'h1;
                    end else if (sclFall && cnt_q == 4'h8) begin
                        cnt_d = 4'h0;
                        oe_d  = 1'b1;
                        st_d  = ST_ACK;
                        if (st_q == ST_ADDR) begin
                            rw_d = sh_q[0];
                            if (sh_q[7:1] != DEV_ADDR) begin
                                oe_d = 1'b0;
                                st_d = ST_IDLE;
                            end
                        end else if (!ptrOk_q) begin
                            ptr_d   = sh_q;
                            ptrOk_d = 1'b1;
                        end else begin
                            wr_d  = '{valid: 1'b1, addr: ptr_q, data: sh_q};
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                ST_ACK: if (sclFall) begin
                    if (rw_q) begin
                        sh_d = rdData;
                        oe_d = ~rdData[7];
                        st_d = ST_SEND;
                    end else begin
                        oe_d = 1'b0;
                        st_d = ST_RECV;
                    end
                end
                ST_SEND: begin
                    if (sclRise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (sclFall && cnt_q == 4'h8) begin
                        cnt_d = 4'h0;
                        oe_d  = 1'b0;
                        st_d  = ST_MACK;
                    end else if (sclFall) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                end
                ST_MACK: begin
                    if (sclRise && pinS_q[0]) begin
                        st_d = ST_IDLE;
                    end else if (sclRise) begin
                        ptr_d = ptr_q + 8'h01;
                    end else if (sclFall) begin
                        sh_d = rdData;
                        oe_d = ~rdData[7];
                        st_d = ST_SEND;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pinM_q  <= 2'h3;
            pinS_q  <= 2'h3;
            pinP_q  <= 2'h3;
            st_q    <= ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            ptrOk_q <= 1'b0;
            sdaOe   <= 1'b0;
            wr      <= '0;
        end else begin
            pinM_q  <= {scl, sdaIn};
            pinS_q  <= pinM_q;
            pinP_q  <= pinS_q;
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            ptrOk_q <= ptrOk_d;
            sdaOe   <= oe_d;
            wr      <= wr_d;
        end
    end

endmodule

`default_nettype wire

//--- rtl/fml_fault_regs.sv
// Fault status, report masking, latching and clearing registers of the
// amplifier, reached over the two-wire control port.
// Assumes fault conditions arrive as asynchronous levels from analog
// monitors and that the control port pins are open drain.

`default_nettype none

module fml_fault_regs
    import fml_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2c  // Arbitrary port address.
) (
    input  wire logic      mclk,          // 25 MHz system clock.
    input  wire logic      rstn,          // Asynchronous reset, low.
    input  wire logic      scl,           // Control port clock pin.
    input  wire logic      sdaIn,         // Control port data level.
    output var  logic      sdaOut,        // Data drive value, always 0.
    output var  logic      sdaOe,         // High while pulling data low.
    input  wire fml_cond_t cond,          // Raw fault conditions.
    output var  logic      faultReportN,  // Unmasked fault, active low.
    output var  logic      thermShutdown  // Power stage shutdown.
);

    ////////////////////////////////////////////////////////////////////
    // Condition synchronisers.

    logic [COND_W-1:0] condM_q, condS_q;
    fml_cond_t         cs;

    genvar gi;
    generate
        for (gi = 0; gi < COND_W; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    condM_q[gi] <= 1'b0;
                    condS_q[gi] <= 1'b0;
                end else begin
                    condM_q[gi] <= cond[gi];
                    condS_q[gi] <= condM_q[gi];
                end
            end
        end
    endgenerate

    assign cs = fml_cond_t'(condS_q);

    ////////////////////////////////////////////////////////////////////
    // Control port.

    fml_wr_t    wr;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic       oeInt;

    fml_i2c_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .mclk   (mclk),
        .rstn   (rstn),
        .scl    (scl),
        .sdaIn  (sdaIn),
        .sdaOe  (oeInt),
        .wr     (wr),
        .rdAddr (rdAddr),
        .rdData (rdData)
    );

    ////////////////////////////////////////////////////////////////////
    // Software registers.

    logic [7:0] mask_q, mask_d;
    logic [7:0] latch_q, latch_d;
    logic [7:0] misc_q, misc_d;
    logic [6:0] clrRsv_q, clrRsv_d;
    logic       clrCmd;

    // The clear bit is never stored, so it reads back as zero.
    assign clrCmd = wr.valid && wr.addr == CLR_ADDR
                    && wr.data[CLR_BIT];

    always_comb begin
        mask_d   = mask_q;
        latch_d  = latch_q;
        misc_d   = misc_q;
        clrRsv_d = clrRsv_q;
        if (wr.valid) begin
            case (wr.addr)
                MASK_ADDR:  mask_d   = wr.data;
                LATCH_ADDR: latch_d  = wr.data;
                MISC_ADDR:  misc_d   = wr.data;
                CLR_ADDR:   clrRsv_d = wr.data[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mask_q   <= MASK_RST;
            latch_q  <= LATCH_RST;
            misc_q   <= MISC_RST;
            clrRsv_q <= CLR_RST;
        end else begin
            mask_q   <= mask_d;
            latch_q  <= latch_d;
            misc_q   <= misc_d;
            clrRsv_q <= clrRsv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault flags. In every flag the live condition sets before the
    // release term clears, so an event in the clearing cycle survives.

    logic [3:0] chan_q, chan_d;
    logic [1:0] rail_q, rail_d;
    logic       clk_q, clk_d;
    logic       tsd_q, tsd_d;
    logic       warn_q, warn_d;
    logic       det_q, det_d;
    logic       tsdRel;
    logic [3:0] chanCond;

    assign chanCond = {cs.leftDc, cs.rightDc, cs.leftOc, cs.rightOc};

    // Auto recovery only frees the flag once the die has cooled.
    assign tsdRel = clrCmd
                    | (misc_q[AUTO_BIT] & ~cs.thermShut);

    always_comb begin
        // Channel and rail faults are analog faults and always latch.
        chan_d = chanCond | (chan_q & ~{4{clrCmd}});
        rail_d = {cs.railOv, cs.railUv} | (rail_q & ~{2{clrCmd}});
        clk_d  = cs.clockErr
                 | (latch_q[LE_CLK] & clk_q & ~clrCmd);
        tsd_d  = cs.thermShut
                 | (latch_q[LE_TSD] & tsd_q & ~tsdRel);
        warn_d = cs.thermWarn
                 | (latch_q[LE_WARN] & warn_q & ~clrCmd);
        det_d  = cs.clockDet
                 | (misc_q[HOLD_BIT] & det_q & ~clrCmd);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chan_q <= 4'h0;
            rail_q <= 2'h0;
            clk_q  <= 1'b0;
            tsd_q  <= 1'b0;
            warn_q <= 1'b0;
            det_q  <= 1'b0;
        end else begin
            chan_q <= chan_d;
            rail_q <= rail_d;
            clk_q  <= clk_d;
            tsd_q  <= tsd_d;
            warn_q <= warn_d;
            det_q  <= det_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault report and pin outputs. Masks only hide a fault from the
    // report pin; the shutdown path and the status bits still see it.

    logic [7:0] srcVec;
    logic [7:0] reportVec;
    logic       warnRep;
    logic       repN_d;

    assign srcVec = {tsd_q, cs.coreUv, cs.coreOv, clk_q,
                     rail_q[0], rail_q[1], |chan_q[3:2], |chan_q[1:0]};
    assign reportVec = srcVec & ~mask_q;
    assign warnRep   = warn_q & ~latch_q[MSK_WARN];
    assign repN_d    = ~(|reportVec | warnRep);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            faultReportN  <= 1'b1;
            thermShutdown <= 1'b0;
            sdaOut        <= 1'b0;
            sdaOe         <= 1'b0;
        end else begin
            faultReportN  <= repN_d;
            thermShutdown <= tsd_q;
            sdaOut        <= 1'b0;
            sdaOe         <= oeInt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux. Unmapped addresses read as zero.

    always_comb begin
        case (rdAddr)
            CHAN_ADDR:  rdData = {4'h0, chan_q};
            GLOB_ADDR:  rdData = {5'h00, clk_q, rail_q};
            TSD_ADDR:   rdData = {7'h00, tsd_q};
            WARN_ADDR:  rdData = {5'h00, warn_q, 2'h0};
            MASK_ADDR:  rdData = mask_q;
            LATCH_ADDR: rdData = latch_q;
            MISC_ADDR:  rdData = misc_q;
            CLR_ADDR:   rdData = {1'b0, clrRsv_q};
            DET_ADDR:   rdData = {7'h00, det_q};
            default:    rdData = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence clrWrite_s;
        wr.valid && wr.addr == CLR_ADDR && wr.data[CLR_BIT];
    endsequence

    sequence condGone_s;
        !cs.leftOc && !cs.rightOc && !cs.leftDc && !cs.rightDc;
    endsequence

    tsd_status_a: assert property (
        rdAddr == TSD_ADDR |-> rdData == {7'h00, tsd_q})
        else $error("thermal shutdown status mismatch");

    warn_set_a: assert property (
        cs.thermWarn |=> warn_q
                         && (rdAddr != WARN_ADDR || rdData[WARN_BIT]))
        else $error("thermal warning not reported");

    tsd_mask_a: assert property (
        mask_q[7] |-> !reportVec[7])
        else $error("masked thermal shutdown reported");

    supply_mask_a: assert property (
        (mask_q & 8'h6c) == 8'h6c |-> (reportVec & 8'h6c) == 8'h00)
        else $error("masked supply fault reported");

    clock_mask_a: assert property (
        !mask_q[4] && clk_q |=> !faultReportN)
        else $error("unmasked clock fault not reported");

    chan_mask_a: assert property (
        (mask_q[1:0] == 2'h3 && !warnRep && (srcVec[7:2] == 6'h00))
        |=> faultReportN)
        else $error("masked channel fault reported");

    clk_latch_a: assert property (
        latch_q[LE_CLK] && clk_q && !clrCmd |=> clk_q [*1])
        else $error("clock fault latch dropped");

    tsd_latch_a: assert property (
        latch_q[LE_TSD] && tsd_q && !clrCmd && !misc_q[AUTO_BIT]
        |=> tsd_q ##1 thermShutdown)
        else $error("thermal shutdown latch dropped");

    warn_latch_a: assert property (
        !latch_q[LE_WARN] && !cs.thermWarn |=> !warn_q)
        else $error("unlatched warning did not follow");

    warn_mask_a: assert property (
        latch_q[MSK_WARN] |-> !warnRep)
        else $error("masked warning reported");

    det_live_a: assert property (
        !misc_q[HOLD_BIT] |=> det_q == $past(cs.clockDet))
        else $error("clock detect status not live");

    auto_rec_a: assert property (
        misc_q[AUTO_BIT] && tsd_q && !cs.thermShut |=> !tsd_q)
        else $error("auto recovery did not release");

    clear_a: assert property (
        clrWrite_s ##0 condGone_s |=> chan_q == 4'h0)
        else $error("clear command left channel faults");

    chan_set_a: assert property (
        $rose(cs.leftOc) |=> chan_q[1] ##1 (chan_q[1] || $past(clrCmd)))
        else $error("left overcurrent not captured");

    hold_a: assert property (
        chan_q[2] && !clrCmd |=> chan_q[2])
        else $error("latched offset fault dropped");

    // Capture, hold and pin checks: the report pin must follow the unmasked shutdown,
    // warning, core UV, rail UV and overcurrent sources, and the clear command must
    // release the shutdown and clock flags whose condition has gone.
    rdc_set_a: assert property (
        $rose(cs.rightDc) |=> chan_q[2])
        else $error("right offset fault not captured");

    ldc_set_a: assert property (
        $rose(cs.leftDc) |=> chan_q[3])
        else $error("left offset fault not captured");

    roc_set_a: assert property (
        $rose(cs.rightOc) |=> chan_q[0])
        else $error("right overcurrent not captured");

    tsd_set_a: assert property (
        cs.thermShut |=> tsd_q ##1 thermShutdown)
        else $error("shutdown flag not set");

    det_hold_a: assert property (
        misc_q[HOLD_BIT] && det_q && !clrCmd |=> det_q)
        else $error("held detect status dropped");

    tsd_report_a: assert property (
        !mask_q[7] && tsd_q |=> !faultReportN)
        else $error("shutdown not reported");

    tsd_hide_a: assert property (
        mask_q[7] && srcVec[6:0] == 7'h00 && !warnRep |=> faultReportN)
        else $error("masked shutdown reached the pin");

    warn_report_a: assert property (
        !latch_q[MSK_WARN] && warn_q |=> !faultReportN)
        else $error("warning not reported");

    core_report_a: assert property (
        !mask_q[6] && cs.coreUv |=> !faultReportN)
        else $error("core undervoltage not reported");

    rail_report_a: assert property (
        !mask_q[3] && rail_q[0] |=> !faultReportN)
        else $error("rail undervoltage not reported");

    oc_report_a: assert property (
        !mask_q[0] && |chan_q[1:0] |=> !faultReportN)
        else $error("overcurrent not reported");

    tsd_clear_a: assert property (
        clrWrite_s ##0 !cs.thermShut |=> !tsd_q)
        else $error("clear left shutdown flag");

    clk_clear_a: assert property (
        clrWrite_s ##0 !cs.clockErr |=> !clk_q)
        else $error("clear left clock fault");

endmodule

`default_nettype wire

//--- sim/fml_fault_regs_test.sv
// Self-checking bench for the fault register bank, acting as port master.
// Assumes the package and design files are compiled first; the bench
// resolves the open-drain data wire with a pull-up.

`default_nettype none

module fml_fault_regs_test import fml_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0] DEV = 7'h2c;  // Arbitrary port address.
    localparam int         HP  = 10;     // Port half period in mclk cycles.

    logic      mclk;
    logic      rstn;
    logic      scl;
    logic      sdaM;
    fml_cond_t cond;
    logic      sdaOut;
    logic      sdaOe;
    logic      faultReportN;
    logic      thermShutdown;
    wire logic sdaW;
    int        nErrors;
    int        nChecks;

    // Pull-up on the data line: low only while some party pulls it.
    assign sdaW = sdaOe ? sdaOut : sdaM;

    fml_fault_regs #(.DEV_ADDR(DEV)) DUT (
        .mclk         (mclk),
        .rstn         (rstn),
        .scl          (scl),
        .sdaIn        (sdaW),
        .sdaOut       (sdaOut),
        .sdaOe        (sdaOe),
        .cond         (cond),
        .faultReportN (faultReportN),
        .thermShutdown(thermShutdown)
    );

    always #20 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
                        input string msg);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string msg);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %0t %s: got %b want %b", $time, msg, got, exp);
        end
    endtask

    task automatic pins(input logic rep, input logic shut);
        cmp1(faultReportN, rep, "fault report pin");
        cmp1(thermShutdown, shut, "shutdown pin");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Start also serves as repeated start: data rises before clock rises.
    task automatic pStart();
        sdaM = 1'b1;
        tick(HP);
        scl = 1'b1;
        tick(HP);
        sdaM = 1'b0;
        tick(HP);
        scl = 1'b0;
        tick(HP);
    endtask

    task automatic pStop();
        sdaM = 1'b0;
        tick(HP);
        scl = 1'b1;
        tick(HP);
        sdaM = 1'b1;
        tick(HP);
    endtask

    task automatic bitIo(input logic b, output logic r);
        sdaM = b;
        tick(HP);
        scl = 1'b1;
        tick(HP);
        r = sdaW;
        scl = 1'b0;
        tick(1);
    endtask

    task automatic byteIo(input logic [7:0] d, input logic m,
                          output logic [7:0] q, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(d[i], r);
            q[i] = r;
        end
        bitIo(m, a);
    endtask

    task automatic wrReg(input logic [7:0] addr, input logic [7:0] d);
        logic [7:0] q;
        logic       k0, k1, k2;
        pStart();
        byteIo({DEV, 1'b0}, 1'b1, q, k0);
        byteIo(addr, 1'b1, q, k1);
        byteIo(d, 1'b1, q, k2);
        pStop();
        cmp1(k0 | k1 | k2, 1'b0, "write acknowledge");
    endtask

    task automatic chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] q, x;
        logic       k0, k1, k2, k3;
        pStart();
        byteIo({DEV, 1'b0}, 1'b1, x, k0);
        byteIo(addr, 1'b1, x, k1);
        pStart();
        byteIo({DEV, 1'b1}, 1'b1, x, k2);
        byteIo(8'hff, 1'b1, q, k3);
        pStop();
        cmp1(k0 | k1 | k2, 1'b0, "read acknowledge");
        cmp8(q, exp, "register read");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        pins(1'b1, 1'b0);
        wrReg(TSD_ADDR, 8'hff);
        chk(TSD_ADDR, 8'h00);
        chk(WARN_ADDR, 8'h00);
        chk(MASK_ADDR, 8'h00);
        chk(LATCH_ADDR, 8'hf8);
        chk(MISC_ADDR, 8'h00);
        chk(CLR_ADDR, 8'h00);
        chk(CHAN_ADDR, 8'h00);
        chk(8'h7f, 8'h00);
        $display("test reset done");
    endtask

    task automatic testShutdown();
        cond.thermShut = 1'b1;
        tick(6);
        pins(1'b0, 1'b1);
        chk(TSD_ADDR, 8'h01);
        cond.thermShut = 1'b0;
        tick(6);
        chk(TSD_ADDR, 8'h01);
        wrReg(MASK_ADDR, 8'h80);
        pins(1'b1, 1'b1);
        wrReg(CLR_ADDR, 8'h80);
        tick(2);
        pins(1'b1, 1'b0);
        chk(TSD_ADDR, 8'h00);
        chk(CLR_ADDR, 8'h00);
        wrReg(MASK_ADDR, 8'h00);
        $display("test shutdown done");
    endtask

    task automatic testWarn();
        cond.thermWarn = 1'b1;
        tick(6);
        chk(WARN_ADDR, 8'h04);
        pins(1'b0, 1'b0);
        cond.thermWarn = 1'b0;
        tick(6);
        chk(WARN_ADDR, 8'h04);
        wrReg(LATCH_ADDR, 8'hfc);
        pins(1'b1, 1'b0);
        wrReg(LATCH_ADDR, 8'hf0);
        wrReg(CLR_ADDR, 8'h80);
        cond.thermWarn = 1'b1;
        tick(6);
        pins(1'b0, 1'b0);
        cond.thermWarn = 1'b0;
        tick(6);
        pins(1'b1, 1'b0);
        chk(WARN_ADDR, 8'h00);
        wrReg(LATCH_ADDR, 8'hf8);
        $display("test warning done");
    endtask

    // Each fault on mask bits 6 to 0 is hidden by its own mask bit alone, and by no other.
    task automatic testMasks();
        int          cb[7] = '{7, 6, 9, 5, 4, 1, 3};
        int          mb[7] = '{6, 5, 4, 3, 2, 1, 0};
        logic [11:0] c;
        for (int i = 0; i < 7; i++) begin
            c = '0;
            c[cb[i]] = 1'b1;
            cond = fml_cond_t'(c);
            tick(6);
            pins(1'b0, 1'b0);
            wrReg(MASK_ADDR, 8'h01 << mb[i]);
            pins(1'b1, 1'b0);
            wrReg(MASK_ADDR, 8'hff ^ (8'h01 << mb[i]));
            pins(1'b0, 1'b0);
            cond = '0;
            wrReg(MASK_ADDR, 8'h00);
            wrReg(CLR_ADDR, 8'h80);
            tick(2);
            pins(1'b1, 1'b0);
        end
        $display("test masks done");
    endtask

    task automatic testChannel();
        cond.leftOc = 1'b1;
        tick(6);
        chk(CHAN_ADDR, 8'h02);
        cond = '0;
        cond.rightDc = 1'b1;
        tick(6);
        chk(CHAN_ADDR, 8'h06);
        cond = '0;
        wrReg(CLR_ADDR, 8'h80);
        cond.rightOc = 1'b1;
        cond.leftDc = 1'b1;
        tick(6);
        chk(CHAN_ADDR, 8'h09);
        cond = '0;
        wrReg(CLR_ADDR, 8'h80);
        chk(CHAN_ADDR, 8'h00);
        $display("test channel done");
    endtask

    task automatic testClock();
        wrReg(LATCH_ADDR, 8'hd8);
        cond.clockErr = 1'b1;
        tick(6);
        pins(1'b0, 1'b0);
        cond.clockErr = 1'b0;
        tick(6);
        pins(1'b1, 1'b0);
        wrReg(LATCH_ADDR, 8'hf8);
        cond.clockErr = 1'b1;
        tick(6);
        cond.clockErr = 1'b0;
        tick(6);
        pins(1'b0, 1'b0);
        chk(GLOB_ADDR, 8'h04);
        wrReg(CLR_ADDR, 8'h80);
        cond.clockDet = 1'b1;
        tick(6);
        chk(DET_ADDR, 8'h01);
        cond.clockDet = 1'b0;
        tick(6);
        chk(DET_ADDR, 8'h00);
        wrReg(MISC_ADDR, 8'h80);
        chk(MISC_ADDR, 8'h80);
        cond.clockDet = 1'b1;
        tick(6);
        cond.clockDet = 1'b0;
        tick(6);
        chk(DET_ADDR, 8'h01);
        wrReg(CLR_ADDR, 8'h80);
        chk(DET_ADDR, 8'h00);
        wrReg(MISC_ADDR, 8'h00);
        $display("test clock done");
    endtask

    task automatic testRecovery();
        wrReg(MISC_ADDR, 8'h10);
        cond.thermShut = 1'b1;
        tick(6);
        pins(1'b0, 1'b1);
        cond.thermShut = 1'b0;
        tick(6);
        pins(1'b1, 1'b0);
        chk(TSD_ADDR, 8'h00);
        wrReg(MISC_ADDR, 8'h00);
        $display("test recovery done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic stopTest();
        $display("checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // The tests take about 52000 cycles; this leaves ample margin.
    initial begin
        repeat (95000) @(posedge mclk);
        nErrors++;
        $display("[FAIL] %0t watchdog expired", $time);
        stopTest();
    end

    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        scl = 1'b1;
        sdaM = 1'b1;
        cond = '0;
        nErrors = 0;
        nChecks = 0;
        tick(5);
        rstn = 1'b1;
        tick(4);
        testReset();
        testShutdown();
        testWarn();
        testMasks();
        testChannel();
        testClock();
        testRecovery();
        stopTest();
    end
endmodule

`default_nettype wire
